// file: hw/lfs_params.svh
// constants of the line driver fault supervisor: register map, field positions, reset values, times
// assumes a 20 MHz mclk and an APB slave with 4 address bits
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH

// ==========================================================
// register map
`define LFS_AW           4
`define LFS_OFS_STATUS   4'h0
`define LFS_OFS_LINE_CFG 4'h4
`define LFS_OFS_AUX_CFG  4'h8
`define LFS_OFS_MODE     4'hC

// ==========================================================
// status word fields
`define LFS_ST_AUX_IRQ   6
`define LFS_ST_AUX_LVL   5
`define LFS_ST_LINE_LVL  4
`define LFS_ST_LINE_IRQ  3
`define LFS_ST_LOW_IRQ   2
`define LFS_ST_MAIN_IRQ  1

// line config fields
`define LFS_LC_FILTER    7
`define LFS_LC_FAST      6
`define LFS_LC_POL       5
`define LFS_LC_PP        4
`define LFS_LC_RXMASK    1

// aux config fields
`define LFS_AC_POL       5
`define LFS_AC_PP        4

// mode fields
`define LFS_MD_AUX_FLT   5
`define LFS_MD_LINE_FLT  4
`define LFS_MD_MAIN_LOW  3
`define LFS_MD_MON_PIN   1
`define LFS_MD_REG_OFF   0

// ==========================================================
// reset values
`define LFS_LINE_CFG_RST 8'h00
`define LFS_AUX_CFG_RST  8'h00
`define LFS_MON_PIN_RST  1'b0
`define LFS_REG_OFF_RST  1'b0

// ==========================================================
// flag vector layout
`define LFS_NFLAG        4
`define LFS_F_LINE       0
`define LFS_F_AUX        1
`define LFS_F_MAIN       2
`define LFS_F_LOW        3
`define LFS_NSYNC        13

// ==========================================================
// times in ns and derived cycle counts, least times rounded up
`define LFS_CLK_NS          50
`define LFS_LINE_SHORT_NS   140000
`define LFS_LINE_OFF_NS     240000
`define LFS_AUX_FAULT_NS    440000
`define LFS_RETRY_NS        26000000
`define LFS_CYC(ns)         (((ns) + `LFS_CLK_NS - 1) / `LFS_CLK_NS)

`endif

// file: hw/lfs_pkg.sv
// types shared by the line driver fault supervisor
// assumes the constants header is included by each design file
package lfs_pkg;

	// gray order along idle, pending, off, retry
	typedef enum logic [1:0] {
		LFS_IDLE  = 2'b00,
		LFS_PEND  = 2'b01,
		LFS_OFF   = 2'b11,
		LFS_RETRY = 2'b10
	} lfs_flt_e;

	typedef struct packed {
		logic hs_on;
		logic ls_on;
	} lfs_drv_s;

	typedef struct packed {
		logic main_ok;
		logic v5_ok;
		logic logic_ok;
		logic low_rail_ok;
	} lfs_sup_s;

endpackage

// file: hw/lfs_fault_timer.sv
// fault timing and auto-retry for one output driver
// assumes synchronised, same-clock short and level error inputs
`timescale 1ns/1ns
`include "lfs_params.svh"

module lfs_fault_timer import lfs_pkg::*; #(
	parameter int unsigned DET_CYC   = 2,
	parameter int unsigned OFF_CYC   = 4,
	parameter int unsigned RETRY_CYC = 16,
	parameter int unsigned CW        = 20
) (
	input  wire logic mclk,          // system clock
	input  wire logic rst_n,         // synchronous reset
	input  wire logic ce,            // clock enable
	input  wire logic short_det,     // driver in current limit
	input  wire logic level_err,     // level error, already gated
	output logic      fault_pulse,   // fault registered
	output logic      fault_active,  // fault still present
	output logic      driver_off     // driver forced off
);

	lfs_flt_e        state;
	logic [CW-1:0]   cnt;
	logic            cond;
	logic            next_event;
	logic            next_clear;

	assign cond       = short_det | level_err;
	assign driver_off = (state == LFS_OFF);
	assign next_event = !fault_active && (state == LFS_PEND) && cond &&
	                    (level_err || (cnt == CW'(DET_CYC)));
	assign next_clear = !cond && ((state == LFS_PEND) ||
	                    ((state == LFS_RETRY) && (cnt == CW'(OFF_CYC))));

	// ==========================================================
	// state and time spent in the current state
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= LFS_IDLE;
			cnt   <= '0;
		end else if (ce) begin
			case (state)
				LFS_IDLE: begin
					cnt <= CW'(1);
					if (cond) begin
						state <= LFS_PEND;
					end
				end
				LFS_PEND: begin
					if (!cond) begin
						state <= LFS_IDLE;
					end else if (cnt == CW'(OFF_CYC)) begin
						state <= LFS_OFF;
						cnt   <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				LFS_OFF: begin
					// the gap is shortened so attempts start one retry period apart
					if (cnt == CW'(RETRY_CYC - OFF_CYC)) begin
						state <= LFS_RETRY;
						cnt   <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				LFS_RETRY: begin
					if (cnt == CW'(OFF_CYC)) begin
						state <= cond ? LFS_OFF : LFS_IDLE;
						cnt   <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				default: begin
					state <= LFS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// registered fault and its persistence
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fault_pulse  <= 1'b0;
			fault_active <= 1'b0;
		end else if (ce) begin
			fault_pulse <= next_event;
			if (next_event) begin
				fault_active <= 1'b1;
			end else if (next_clear) begin
				fault_active <= 1'b0;
			end
		end
	end

endmodule

// file: hw/lfs_top.sv
// line driver fault supervisor: driver selection, receive masking, fault timing, supply monitor, APB registers
// assumes pins arrive asynchronously and an APB master on mclk
//
// What this block does
// RL1 - push-pull select drives line both ways
// RL2 - aux push-pull select drives aux both ways
// RL3 - polarity bit picks sink or source switch
// RL4 - line driver off while transmit enable low
// RL5 - software sets fast edges for fast rates
// RL6 - receiver always on; mask forces output high
// RL7 - one bit selects both filter corners
// RL8 - line short over 140us is a fault
// RL9 - open-drain level error is a fault
// RL10 - line fault sets flags, irq, off 240us
// RL11 - line auto-retry 240us every 26ms
// RL12 - aux short for 440us is a fault
// RL13 - aux auto-retry 440us every 26ms
// RL14 - aux fault sets flags, irq, off 440us
// RL15 - mode bit switches low rail regulator off
// RL16 - drivers, indicator off until supplies up
// RL17 - supply undervoltage disables both drivers
// RL18 - main supply low sets flags and irq
// RL19 - registers kept; bus, irq gone on UV
// RL20 - low rail low flags; pin if enabled
// RL21 - indicator follows; flags held until read
// RL22 - line level is inverse AND of data
// RL23 - status read clears; persisting faults reset
// RL24 - irq low while any irq flag set
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "lfs_params.svh"

module lfs_top import lfs_pkg::*; #(
	parameter int unsigned LINE_OFF_CYC  = `LFS_CYC(`LFS_LINE_OFF_NS),
	parameter int unsigned AUX_FAULT_CYC = `LFS_CYC(`LFS_AUX_FAULT_NS),
	parameter int unsigned RETRY_CYC     = `LFS_CYC(`LFS_RETRY_NS)
) (
	input  wire logic              mclk,                      // 20 MHz clock
	input  wire logic              rst_n,                     // synchronous reset
	input  wire logic              ce,                        // clock enable
	input  wire logic              psel,                      // apb select
	input  wire logic              penable,                   // apb enable
	input  wire logic              pwrite,                    // apb direction
	input  wire logic [`LFS_AW-1:0] paddr,                    // apb address
	input  wire logic [31:0]       pwdata,                    // apb write data
	output logic      [31:0]       prdata,                    // apb read data
	output logic                   pready,                    // apb ready
	output logic                   pslverr,                   // apb error
	input  wire logic              transmit_drive_enable,     // line driver enable pin
	input  wire logic              line_tx_data_a,            // transmit data a
	input  wire logic              line_tx_data_b,            // transmit data b
	input  wire logic              line_level,                // line above receive threshold
	input  wire logic              line_level_err,            // line between thresholds
	input  wire logic              line_current_limit,        // line driver in limit
	input  wire logic              aux_drive_in,              // aux output logic input
	input  wire logic              aux_current_limit,         // aux driver in limit
	input  wire logic              aux_digital_in,            // aux input comparator
	input  wire lfs_sup_s          supply,                    // supply monitors
	output lfs_drv_s               line_drv,                  // line switch gates
	output lfs_drv_s               aux_drv,                   // aux switch gates
	output logic                   fast_edge,                 // slew select to drivers
	output logic                   filter_corner,             // 1 picks higher corner
	output logic                   rx_out,                    // receive output
	output logic                   aux_logic_out,             // aux input logic output
	output logic                   undervoltage_indicator_oe, // high pulls indicator low
	output logic                   irq_n,                     // interrupt request
	output logic                   low_rail_regulator_off     // regulator shut-off
);

	localparam int unsigned LINE_DET_CYC = `LFS_CYC(`LFS_LINE_SHORT_NS);

	logic [`LFS_NSYNC-1:0] sync1, sync2, raw;
	logic [7:0]            line_cfg, aux_cfg;
	logic                  low_rail_monitor_to_pin;
	logic                  powered_up;
	logic [`LFS_NFLAG-1:0] irq_flag, fault_flag, next_set;
	logic [31:0]           next_rdata;
	logic                  next_err;
	lfs_drv_s              next_line_drv, next_aux_drv;
	lfs_sup_s              sup_s;
	logic                  transmit_drive_enable_s, tx_a_s, tx_b_s, lvl_s, lvl_err_s, line_cl_s, aux_in_s, aux_cl_s, din_s;
	logic                  supplies_ok, bus_ok, drv_ok, acc, wr, status_rd;
	logic                  line_pulse, line_active, line_off, line_lvl_err;
	logic                  aux_pulse, aux_active, aux_off, line_tx_lvl, aux_tx_lvl;

	// ==========================================================
	// pin synchronisers
	assign raw = {supply, transmit_drive_enable, line_tx_data_a, line_tx_data_b, line_level,
	              line_level_err, line_current_limit, aux_drive_in, aux_current_limit, aux_digital_in};

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (ce) begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	assign {sup_s, transmit_drive_enable_s, tx_a_s, tx_b_s, lvl_s, lvl_err_s, line_cl_s, aux_in_s, aux_cl_s, din_s} = sync2;
	assign supplies_ok = sup_s.main_ok & sup_s.v5_ok & sup_s.logic_ok;
	assign bus_ok      = sup_s.v5_ok & sup_s.logic_ok;
	assign drv_ok      = powered_up & supplies_ok;

	// ==========================================================
	// power-up gate
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			powered_up <= 1'b0;
		// RL16 wait for supplies
		end else if (ce && supplies_ok && sup_s.low_rail_ok) begin
			powered_up <= 1'b1;
		end
	end

	// ==========================================================
	// driver selection
	// RL22 inverse and of data
	assign line_tx_lvl = ~(tx_a_s & tx_b_s);
	assign aux_tx_lvl  = ~aux_in_s;

	always_comb begin
		next_line_drv = '0;
		next_aux_drv  = '0;
		// RL4 RL17 driver enable gating
		if (drv_ok && transmit_drive_enable_s && !line_off) begin
			// RL1 push-pull line
			if (line_cfg[`LFS_LC_PP]) begin
				next_line_drv.hs_on = line_tx_lvl;
				next_line_drv.ls_on = ~line_tx_lvl;
			// RL3 line switch polarity
			end else if (line_cfg[`LFS_LC_POL]) begin
				next_line_drv.hs_on = line_tx_lvl;
			end else begin
				next_line_drv.ls_on = ~line_tx_lvl;
			end
		end
		// RL17 aux off on undervoltage
		if (drv_ok && !aux_off) begin
			// RL2 push-pull aux
			if (aux_cfg[`LFS_AC_PP]) begin
				next_aux_drv.hs_on = aux_tx_lvl;
				next_aux_drv.ls_on = ~aux_tx_lvl;
			// RL3 aux switch polarity
			end else if (aux_cfg[`LFS_AC_POL]) begin
				next_aux_drv.hs_on = aux_tx_lvl;
			end else begin
				next_aux_drv.ls_on = ~aux_tx_lvl;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			line_drv <= '0;
			aux_drv  <= '0;
		end else if (ce) begin
			line_drv <= next_line_drv;
			aux_drv  <= next_aux_drv;
		end
	end

	// ==========================================================
	// receive path and analog selects
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rx_out                 <= 1'b1;
			aux_logic_out          <= 1'b1;
			fast_edge              <= 1'b0;
			filter_corner          <= 1'b0;
		end else if (ce) begin
			// RL6 mask forces high
			rx_out        <= line_cfg[`LFS_LC_RXMASK] | ~lvl_s;
			aux_logic_out <= ~din_s;
			// RL5 edge rate select
			fast_edge     <= line_cfg[`LFS_LC_FAST];
			// RL7 shared filter corner
			filter_corner <= line_cfg[`LFS_LC_FILTER];
		end
	end

	// ==========================================================
	// fault timers
	// RL9 open-drain switch off
	assign line_lvl_err = powered_up & ~line_cfg[`LFS_LC_PP] & ~(line_drv.hs_on | line_drv.ls_on) & lvl_err_s;

	// RL8 RL10 RL11 line timing
	lfs_fault_timer #(
		.DET_CYC   (LINE_DET_CYC),
		.OFF_CYC   (LINE_OFF_CYC),
		.RETRY_CYC (RETRY_CYC)
	) u_line_timer (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.ce           (ce),
		.short_det    (line_cl_s),
		.level_err    (line_lvl_err),
		.fault_pulse  (line_pulse),
		.fault_active (line_active),
		.driver_off   (line_off)
	);

	// RL12 RL13 RL14 aux timing
	lfs_fault_timer #(
		.DET_CYC   (AUX_FAULT_CYC),
		.OFF_CYC   (AUX_FAULT_CYC),
		.RETRY_CYC (RETRY_CYC)
	) u_aux_timer (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.ce           (ce),
		.short_det    (aux_cl_s),
		.level_err    (1'b0),
		.fault_pulse  (aux_pulse),
		.fault_active (aux_active),
		.driver_off   (aux_off)
	);

	// ==========================================================
	// flags: set wins over the read clear
	always_comb begin
		next_set = '0;
		// RL23 persisting faults set again
		next_set[`LFS_F_LINE] = line_pulse | line_active;
		next_set[`LFS_F_AUX]  = aux_pulse | aux_active;
		// RL18 main supply monitor
		next_set[`LFS_F_MAIN] = powered_up & ~sup_s.main_ok;
		// RL20 low rail, ignored while switched off
		next_set[`LFS_F_LOW]  = powered_up & ~sup_s.low_rail_ok & ~low_rail_regulator_off;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `LFS_NFLAG; gi = gi + 1) begin : g_flag
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					irq_flag[gi]   <= 1'b0;
					fault_flag[gi] <= 1'b0;
				end else if (ce) begin
					// RL21 RL23 held until status read
					irq_flag[gi]   <= next_set[gi] | (irq_flag[gi] & ~status_rd);
					fault_flag[gi] <= next_set[gi] | (fault_flag[gi] & ~status_rd);
				end
			end
		end
	endgenerate

	// ==========================================================
	// indicator and interrupt
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			undervoltage_indicator_oe <= 1'b0;
			irq_n                     <= 1'b1;
		end else if (ce) begin
			// RL16 RL18 RL20 RL21 indicator follows supplies
			undervoltage_indicator_oe <= drv_ok & (sup_s.low_rail_ok | ~low_rail_monitor_to_pin);
			// RL19 RL24 irq only with logic supplies
			irq_n <= ~(bus_ok & (|irq_flag));
		end
	end

	// ==========================================================
	// apb slave, one wait state
	assign acc       = psel & penable & pready;
	assign wr        = acc & pwrite & ~pslverr;
	assign status_rd = acc & ~pwrite & ~pslverr & (paddr == `LFS_OFS_STATUS);

	always_comb begin
		next_rdata = '0;
		// RL19 bus refused on undervoltage
		next_err   = ~bus_ok;
		if (paddr == `LFS_OFS_STATUS) begin
			next_rdata[`LFS_ST_AUX_IRQ]  = irq_flag[`LFS_F_AUX];
			next_rdata[`LFS_ST_AUX_LVL]  = din_s;
			next_rdata[`LFS_ST_LINE_LVL] = lvl_s;
			next_rdata[`LFS_ST_LINE_IRQ] = irq_flag[`LFS_F_LINE];
			next_rdata[`LFS_ST_LOW_IRQ]  = irq_flag[`LFS_F_LOW];
			next_rdata[`LFS_ST_MAIN_IRQ] = irq_flag[`LFS_F_MAIN];
		end else if (paddr == `LFS_OFS_LINE_CFG) begin
			next_rdata[7:0] = line_cfg;
		end else if (paddr == `LFS_OFS_AUX_CFG) begin
			next_rdata[7:0] = aux_cfg;
		end else if (paddr == `LFS_OFS_MODE) begin
			next_rdata[`LFS_MD_AUX_FLT]  = fault_flag[`LFS_F_AUX];
			next_rdata[`LFS_MD_LINE_FLT] = fault_flag[`LFS_F_LINE];
			next_rdata[`LFS_MD_MAIN_LOW] = fault_flag[`LFS_F_MAIN];
			next_rdata[`LFS_MD_MON_PIN]  = low_rail_monitor_to_pin;
			next_rdata[`LFS_MD_REG_OFF]  = low_rail_regulator_off;
		end else begin
			next_err = 1'b1;
		end
		if (pwrite) begin
			next_rdata = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready <= psel & penable & ~pready;
			if (psel && penable && !pready) begin
				prdata  <= next_rdata;
				pslverr <= next_err;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ==========================================================
	// configuration registers; only reset clears them, supply dips do not
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			line_cfg                <= `LFS_LINE_CFG_RST;
			aux_cfg                 <= `LFS_AUX_CFG_RST;
			low_rail_monitor_to_pin <= `LFS_MON_PIN_RST;
		end else if (ce && wr) begin
			if (paddr == `LFS_OFS_LINE_CFG) begin
				line_cfg <= pwdata[7:0];
			end else if (paddr == `LFS_OFS_AUX_CFG) begin
				aux_cfg <= pwdata[7:0];
			end else if (paddr == `LFS_OFS_MODE) begin
				low_rail_monitor_to_pin <= pwdata[`LFS_MD_MON_PIN];
			end
		end
	end

	// RL15 regulator shut-off bit
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			low_rail_regulator_off <= `LFS_REG_OFF_RST;
		end else if (ce && wr && (paddr == `LFS_OFS_MODE)) begin
			low_rail_regulator_off <= pwdata[`LFS_MD_REG_OFF];
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_line_pp;
		ce && drv_ok && transmit_drive_enable_s && !line_off && line_cfg[`LFS_LC_PP] |=> (line_drv.hs_on ^ line_drv.ls_on);
	endproperty
	a_line_pp: assert property (p_line_pp) else $error("push-pull line not driven one way"); // RL1

	property p_aux_od;
		ce && !aux_cfg[`LFS_AC_PP] && aux_cfg[`LFS_AC_POL] |=> !aux_drv.ls_on;
	endproperty
	a_aux_od: assert property (p_aux_od) else $error("aux source switch sinks"); // RL3

	property p_line_npn;
		ce && !line_cfg[`LFS_LC_PP] && !line_cfg[`LFS_LC_POL] |=> !line_drv.hs_on;
	endproperty
	a_line_npn: assert property (p_line_npn) else $error("line sink switch sources"); // RL3

	property p_transmit_drive_enable_off;
		ce && !transmit_drive_enable_s |=> (line_drv == '0);
	endproperty
	a_transmit_drive_enable_off: assert property (p_transmit_drive_enable_off) else $error("line driven with enable low"); // RL4

	property p_rx_mask;
		ce && line_cfg[`LFS_LC_RXMASK] |=> rx_out;
	endproperty
	a_rx_mask: assert property (p_rx_mask) else $error("masked receive output low"); // RL6

	property p_line_flag;
		ce && line_pulse ##1 ce |=> irq_flag[`LFS_F_LINE] && !irq_n;
	endproperty
	a_line_flag: assert property (p_line_flag) else $error("line fault did not raise irq"); // RL10

	property p_uv_off;
		ce && !supplies_ok |=> (line_drv == '0) && (aux_drv == '0) && !undervoltage_indicator_oe;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("drivers on in undervoltage"); // RL17

	property p_rd_clear;
		ce && status_rd && !next_set[`LFS_F_AUX] |=> !irq_flag[`LFS_F_AUX];
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("aux irq flag kept after read"); // RL23

	property p_irq_hold;
		ce && bus_ok && (|irq_flag) && !status_rd |=> !irq_n [*1] ##0 (|irq_flag);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq released with flag set"); // RL24

	c_line_fault: cover property (line_pulse);
	c_aux_retry:  cover property (aux_off ##1 !aux_off);
	c_status_rd:  cover property (status_rd && (|irq_flag));

endmodule

// file: bench/lfs_host_model.sv
// host side model: a link-layer controller driving the transmit pins
// assumes the bench hands it requests on mclk and owns its timing
`timescale 1ns/1ns

module lfs_host_model (
	input  wire logic       mclk,                  // system clock
	input  wire logic       en_req,                // driver wanted
	input  wire logic [1:0] dat_req,               // wanted data bits b, a
	input  wire logic       solo,                  // only input a in use
	output logic            transmit_drive_enable, // enable pin
	output logic            line_tx_data_a,        // data pin a
	output logic            line_tx_data_b         // data pin b
);
	always @(posedge mclk) begin
		transmit_drive_enable <= en_req;
	end

	always @(posedge mclk) begin
		line_tx_data_a <= dat_req[0];
		line_tx_data_b <= solo | dat_req[1];
	end
endmodule

// file: bench/line_driver_fault_supervisor_tb_top.sv
// self-checking bench for the line driver fault supervisor
// assumes the design files and the host model are compiled first
`timescale 1ns/1ns
`include "lfs_params.svh"

module line_driver_fault_supervisor_tb_top import lfs_pkg::*; ;
	localparam logic [3:0] ST = `LFS_OFS_STATUS;
	localparam logic [3:0] LC = `LFS_OFS_LINE_CFG;
	localparam logic [3:0] AC = `LFS_OFS_AUX_CFG;
	localparam logic [3:0] MD = `LFS_OFS_MODE;
	logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, en_req = 1, solo = 0, pk = 0;
	logic        line_level = 0, line_level_err = 0, line_current_limit = 0;
	logic        aux_drive_in = 0, aux_current_limit = 0, aux_digital_in = 0;
	logic [1:0]  dat_req = 2'h3;
	logic [3:0]  paddr = 4'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, fast_edge, filter_corner, rx_out, aux_logic_out;
	logic        undervoltage_indicator_oe, irq_n, low_rail_regulator_off;
	logic        transmit_drive_enable, line_tx_data_a, line_tx_data_b;
	lfs_sup_s    supply = '0;
	lfs_drv_s    line_drv, aux_drv;
	logic [64:0] aq[$];
	logic [21:0] pq[$];
	int          n_errors = 0, check_count = 0;
	wire [10:0]  obs = {line_drv, aux_drv, rx_out, aux_logic_out, undervoltage_indicator_oe, irq_n,
		fast_edge, filter_corner, low_rail_regulator_off};

	always #25 mclk = ~mclk;

	lfs_host_model i_lfs_host_model (.mclk(mclk), .en_req(en_req), .dat_req(dat_req), .solo(solo),
		.transmit_drive_enable(transmit_drive_enable), .line_tx_data_a(line_tx_data_a),
		.line_tx_data_b(line_tx_data_b));

	// short retry period keeps the run small; detect and off counts stay real
	lfs_top #(.LINE_OFF_CYC(4800), .AUX_FAULT_CYC(8800), .RETRY_CYC(10000)) i_lfs_top (.mclk(mclk), .rst_n(rst_n),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .transmit_drive_enable(transmit_drive_enable),
		.line_tx_data_a(line_tx_data_a), .line_tx_data_b(line_tx_data_b), .line_level(line_level),
		.line_level_err(line_level_err), .line_current_limit(line_current_limit), .aux_drive_in(aux_drive_in),
		.aux_current_limit(aux_current_limit), .aux_digital_in(aux_digital_in), .supply(supply),
		.line_drv(line_drv), .aux_drv(aux_drv), .fast_edge(fast_edge), .filter_corner(filter_corner),
		.rx_out(rx_out), .aux_logic_out(aux_logic_out), .undervoltage_indicator_oe(undervoltage_indicator_oe),
		.irq_n(irq_n), .low_rail_regulator_off(low_rail_regulator_off));

	// =====
	// checking and closing
	task automatic chk(input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic finish_test;
		if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [1:0] drv(input logic pp, pol, l, en);
		if (!en) return 2'b00;
		if (pp) return {l, ~l};
		return pol ? {l, 1'b0} : {1'b0, ~l};
	endfunction

	always @(posedge mclk) begin
		if (psel && penable && pready) begin
			chk({31'h0, pslverr}, {31'h0, aq[0][64]});
			chk(prdata & aq[0][63:32], aq[0][31:0]);
			void'(aq.pop_front());
		end
		if (pk) begin
			chk({21'h0, obs & pq[0][21:11]}, {21'h0, pq[0][10:0]});
			void'(pq.pop_front());
		end
	end

	// =====
	// bus and pin tasks
	task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d, m, input logic e);
		int k;
		aq.push_back({e, m, w ? 32'h0 : d});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_errors++;
			finish_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so a following call never reassigns psel in this step
		@(posedge mclk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] d, m);
		apb(1'b0, a, d, m, 1'b0);
	endtask

	// pins settle within four edges after a change, so five is safe
	task automatic pins(input logic [10:0] e, m);
		repeat (5) @(posedge mclk);
		pq.push_back({m, e});
		pk <= 1'b1;
		@(posedge mclk);
		pk <= 1'b0;
	endtask

	// =====
	// main sequence
	initial begin
		logic [31:0] r;
		logic [7:0]  c;
		int          i;
		void'($urandom(32'hc21f));
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		pins(11'h060, 11'h7F7);
		supply <= '1;
		pins(11'h270, 11'h7F7);
		rd(ST, 32'h0, 32'h0);
		rd(LC, 32'h0, 32'hFFFF_FFFF);
		rd(AC, 32'h0, 32'hFFFF_FFFF);
		rd(MD, 32'h0, 32'h3);
		apb(1'b0, 4'h2, 32'h0, 32'h0, 1'b1);
		for (i = 0; i < 16; i++) begin
			r = $urandom;
			c = {r[0], r[1], i[1], i[0], 2'b00, r[2], 1'b0};
			wr(LC, {24'h0, c});
			wr(AC, {26'h0, i[3:2], 4'h0});
			en_req <= r[5];
			dat_req <= r[4:3];
			solo <= r[8];
			aux_drive_in <= r[6];
			line_level <= r[7];
			aux_digital_in <= r[9];
			pins({drv(i[0], i[1], ~(r[3] & (r[4] | r[8])), r[5]), drv(i[2], i[3], ~r[6], 1'b1),
				r[2] | ~r[7], ~r[9], 2'b11, r[1], r[0], 1'b0}, 11'h7FF);
			rd(LC, {24'h0, c}, 32'hFFFF_FFFF);
		end
		wr(MD, 32'h1);
		pins(11'h001, 11'h001);
		en_req <= 1'b1;
		dat_req <= 2'h3;
		aux_drive_in <= 1'b1;
		wr(LC, 32'h10);
		wr(AC, 32'h10);
		supply.main_ok <= 1'b0;
		pins(11'h000, 11'h798);
		rd(MD, 32'h8, 32'h8);
		rd(ST, 32'h2, 32'h2);
		supply.main_ok <= 1'b1;
		pins(11'h290, 11'h798);
		rd(ST, 32'h2, 32'h2);
		rd(ST, 32'h0, 32'h2);
		pins(11'h018, 11'h018);
		wr(MD, 32'h2);
		supply.low_rail_ok <= 1'b0;
		pins(11'h280, 11'h798);
		wr(MD, 32'h0);
		pins(11'h290, 11'h798);
		supply.low_rail_ok <= 1'b1;
		rd(ST, 32'h4, 32'h4);
		rd(ST, 32'h0, 32'h4);
		supply.v5_ok <= 1'b0;
		pins(11'h000, 11'h780);
		apb(1'b1, LC, 32'hFF, 32'h0, 1'b1);
		supply.v5_ok <= 1'b1;
		// the restored supply needs its two synchroniser edges before the bus is served
		repeat (3) @(posedge mclk);
		rd(LC, 32'h10, 32'hFFFF_FFFF);
		line_current_limit <= 1'b1;
		repeat (2805) @(posedge mclk);
		rd(ST, 32'h8, 32'h8);
		rd(MD, 32'h10, 32'h10);
		repeat (1970) @(posedge mclk);
		pins(11'h200, 11'h600);
		repeat (20) @(posedge mclk);
		pins(11'h000, 11'h608);
		line_current_limit <= 1'b0;
		pins(11'h000, 11'h600);
		repeat (5700) @(posedge mclk);
		pins(11'h200, 11'h600);
		repeat (4500) @(posedge mclk);
		rd(ST, 32'h8, 32'h8);
		rd(ST, 32'h0, 32'h8);
		aux_current_limit <= 1'b1;
		repeat (8785) @(posedge mclk);
		pins(11'h080, 11'h180);
		repeat (20) @(posedge mclk);
		rd(ST, 32'h40, 32'h40);
		rd(MD, 32'h20, 32'h20);
		pins(11'h000, 11'h188);
		aux_current_limit <= 1'b0;
		// open-drain level error with gates off
		wr(LC, 32'h0);
		dat_req <= 2'h2;
		line_level_err <= 1'b1;
		repeat (10) @(posedge mclk);
		rd(ST, 32'h8, 32'h8);
		// aux short is gone and its off time has run out, so its retry window drives again
		repeat (1400) @(posedge mclk);
		pins(11'h080, 11'h180);
		finish_test();
	end
endmodule
